// [efe_ctrl.sv]
// Control logic of one E1 front-end channel: parallel register port, strap decode,
// template store, driver float control and slicer-to-receive-pin path.
// Assumes clock-loss and reset requests come from logic already on sys_clk.
`timescale 1ns/1ps
module efe_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [5:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic [1:0] ctrl_mode_pins,
    input wire logic driver_hiz_pin,
    input wire logic [1:0] pattern_select_pins,
    input wire logic term_mode_pin,
    input wire logic [1:0] pulse_select_pins,
    input wire logic monitor_gain_pin,
    input wire logic [1:0] path_mode_pins,
    input wire logic mclk_lost,
    input wire logic tclk_lost,
    input wire logic remote_loopback,
    input wire logic pattern_on_mclk,
    input wire logic soft_reset,
    input wire logic [1:0] wave_ui,
    input wire logic [3:0] wave_samp,
    input wire logic wave_wr_en,
    input wire logic [5:0] wave_wr_addr,
    input wire logic [6:0] wave_wr_data,
    input wire logic slicer_pos,
    input wire logic slicer_neg,
    input wire logic cdr_pos,
    input wire logic cdr_neg,
    output logic tx_term_internal,
    output logic tx_term_120,
    output logic rx_term_internal,
    output logic rx_term_120,
    output logic [3:0] pulse_template_select,
    output logic [5:0] amplitude_scale,
    output logic [6:0] wave_sample_data,
    output logic tx_powerdown,
    output logic driver_hiz,
    output logic rx_powerdown,
    output logic [1:0] monitor_gain,
    output logic equalizer_enable,
    output logic rx_sens_20db,
    output logic [4:0] los_level,
    output logic [1:0] slicer_threshold,
    output logic [1:0] rx_mode,
    output logic [1:0] tx_mode,
    output logic cdr_bypass,
    output logic rx_data_pos,
    output logic rx_data_neg,
    output logic rec_clk,
    output logic rec_clk_tick
);
    import efe_pkg::*;

    logic [1:0] slc_q;
    logic [1:0] mode_q;
    logic cs_q;
    logic rd_q;
    logic wr_q;
    logic [5:0] addr_q;
    logic [7:0] din_q;
    logic hz_pin;
    logic [1:0] pat_pins;
    logic term_pin;
    logic [1:0] pulse_template_select_pins;
    logic mon_pin;
    logic [1:0] pm_pins;

    // Strobes are inverted first, so the all-zero reset state reads as idle.
    efe_sync #(.W(17), .INIT(17'h00000)) u_port_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d({~cs_n, ~rd_n, ~wr_n, addr, data_in}),
        .q({cs_q, rd_q, wr_q, addr_q, din_q})
    );
    efe_sync #(.W(9), .INIT(9'h000)) u_strap_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d({driver_hiz_pin, pattern_select_pins, term_mode_pin, pulse_select_pins,
            monitor_gain_pin, path_mode_pins}),
        .q({hz_pin, pat_pins, term_pin, pulse_template_select_pins, mon_pin, pm_pins})
    );
    efe_sync #(.W(2), .INIT(2'h0)) u_mode_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d(ctrl_mode_pins),
        .q(mode_q)
    );
    efe_sync #(.W(2), .INIT(2'h0)) u_slc_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d({slicer_pos, slicer_neg}),
        .q(slc_q)
    );

    // Host port: a write is committed when the write strobe ends, using the
    // address and data held during the strobe, so slow buses settle first.
    logic wr_seen_ff;
    logic [5:0] wr_addr_ff;
    logic [7:0] wr_data_ff;
    logic wr_commit;
    assign wr_commit = wr_seen_ff & ~wr_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_seen_ff <= 1'b0;
            wr_addr_ff <= 6'h00;
            wr_data_ff <= 8'h00;
        end else begin
            wr_seen_ff <= wr_q & cs_q;
            if (wr_q & cs_q) begin
                wr_addr_ff <= addr_q;
                wr_data_ff <= din_q;
            end
        end
    end

    logic [7:0] term_cfg_ff;
    logic [7:0] tx_cfg0_ff;
    logic [7:0] tx_cfg1_ff;
    logic [5:0] scale_ff;
    logic [7:0] rx_cfg0_ff;
    logic [7:0] rx_cfg1_ff;
    logic [7:0] rx_cfg2_ff;
    logic we_term;
    logic we_tx0;
    logic we_tx1;
    logic we_tx2;
    logic we_rx0;
    logic we_rx1;
    logic we_rx2;
    assign we_term = wr_commit & (wr_addr_ff == ADDR_TERM_CFG);
    assign we_tx0 = wr_commit & (wr_addr_ff == ADDR_TX_CFG0);
    assign we_tx1 = wr_commit & (wr_addr_ff == ADDR_TX_CFG1);
    assign we_tx2 = wr_commit & (wr_addr_ff == ADDR_TX_CFG2);
    assign we_rx0 = wr_commit & (wr_addr_ff == ADDR_RX_CFG0);
    assign we_rx1 = wr_commit & (wr_addr_ff == ADDR_RX_CFG1);
    assign we_rx2 = wr_commit & (wr_addr_ff == ADDR_RX_CFG2);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            term_cfg_ff <= RST_TERM_CFG;
            tx_cfg0_ff <= RST_TX_CFG0;
            tx_cfg1_ff <= RST_TX_CFG1;
            scale_ff <= RST_AMP_SCALE;
            rx_cfg0_ff <= RST_RX_CFG0;
            rx_cfg1_ff <= RST_RX_CFG1;
            rx_cfg2_ff <= RST_RX_CFG2;
        end else begin
            if (we_term) term_cfg_ff <= wr_data_ff;
            if (we_tx0) tx_cfg0_ff <= wr_data_ff;
            if (we_tx1) tx_cfg1_ff <= wr_data_ff;
            if (we_tx2) scale_ff <= wr_data_ff[5:0];
            if (we_rx0) rx_cfg0_ff <= wr_data_ff;
            if (we_rx1) rx_cfg1_ff <= wr_data_ff;
            if (we_rx2) rx_cfg2_ff <= wr_data_ff;
        end
    end

    // Register fields and hardware-mode selection.
    logic hw_mode;
    logic [2:0] t_term;
    logic [2:0] r_term;
    logic [3:0] pulse_template_select_reg;
    assign hw_mode = (mode_q == CTRL_MODE_HW);
    assign t_term = term_cfg_ff[TX_TERM_LSB +: 3];
    assign r_term = term_cfg_ff[RX_TERM_LSB +: 3];
    assign pulse_template_select_reg = tx_cfg1_ff[PULSE_LSB +: 4];

    logic nxt_tx_int;
    logic nxt_tx_120;
    logic nxt_rx_int;
    logic nxt_rx_120;
    logic [3:0] nxt_pulse_template_select;
    // Software mode: top bit set means external matching; the pulse setting is the register field.
    // Hardware mode: one pin chooses internal or external for both directions.
    assign nxt_tx_int = hw_mode ? ~term_pin : ~t_term[2];
    assign nxt_tx_120 = hw_mode ? pulse_template_select_pins[0] : t_term[0];
    assign nxt_rx_int = hw_mode ? ~term_pin : ~r_term[2];
    assign nxt_rx_120 = hw_mode ? pulse_template_select_pins[0] : r_term[0];
    assign nxt_pulse_template_select = hw_mode ? ((term_pin | pulse_template_select_pins[0]) ? PULSE_120 : PULSE_75)
                              : pulse_template_select_reg;

    logic arb_wave;
    logic [5:0] nxt_scale;
    assign arb_wave = (nxt_pulse_template_select[3:2] == PULSE_ARB_TOP);
    // Preset templates run at their nominal amplitude whatever the scale field holds.
    assign nxt_scale = arb_wave ? scale_ff : RST_AMP_SCALE;

    logic nxt_tx_off;
    logic nxt_hiz;
    logic tclk_fault;
    assign nxt_tx_off = hw_mode ? (pat_pins == PAT_TX_OFF)
                                : tx_cfg0_ff[TX_OFF_BIT];
    assign tclk_fault = tclk_lost & ~remote_loopback & ~pattern_on_mclk;
    assign nxt_hiz = hz_pin | (~hw_mode & tx_cfg1_ff[DRV_HIZ_BIT]) | nxt_tx_off
                   | mclk_lost | tclk_fault | soft_reset;

    logic [1:0] nxt_gain;
    logic nxt_eq;
    logic [1:0] nxt_rx_mode;
    logic [1:0] nxt_tx_mode;
    logic nxt_bypass;
    // Software must keep gain at 0 dB unless it is bridging a line for monitoring.
    assign nxt_gain = hw_mode ? (mon_pin ? GAIN_26DB : GAIN_0DB)
                              : rx_cfg2_ff[MON_GAIN_LSB +: 2];
    assign nxt_eq = ~hw_mode & rx_cfg1_ff[EQ_EN_BIT];
    assign nxt_rx_mode = hw_mode ? pm_pins : rx_cfg0_ff[RX_MODE_LSB +: 2];
    assign nxt_tx_mode = hw_mode ? pm_pins : tx_cfg0_ff[TX_MODE_LSB +: 2];
    // Only the dual-rail bypass code skips recovery; single rail always recovers.
    assign nxt_bypass = (nxt_rx_mode == RX_MODE_BYPASS);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_term_internal <= 1'b1;
            tx_term_120 <= 1'b0;
            rx_term_internal <= 1'b1;
            rx_term_120 <= 1'b0;
            pulse_template_select <= PULSE_75;
            amplitude_scale <= RST_AMP_SCALE;
            tx_powerdown <= 1'b0;
            driver_hiz <= 1'b1;
            rx_powerdown <= 1'b0;
            monitor_gain <= GAIN_0DB;
            equalizer_enable <= 1'b0;
            rx_sens_20db <= 1'b0;
            los_level <= 5'h00;
            slicer_threshold <= 2'h0;
            rx_mode <= 2'h0;
            tx_mode <= 2'h0;
            cdr_bypass <= 1'b0;
        end else begin
            tx_term_internal <= nxt_tx_int;
            tx_term_120 <= nxt_tx_120;
            rx_term_internal <= nxt_rx_int;
            rx_term_120 <= nxt_rx_120;
            pulse_template_select <= nxt_pulse_template_select;
            amplitude_scale <= nxt_scale;
            tx_powerdown <= nxt_tx_off;
            driver_hiz <= nxt_hiz;
            rx_powerdown <= ~hw_mode & rx_cfg0_ff[RX_OFF_BIT];
            monitor_gain <= nxt_gain;
            equalizer_enable <= nxt_eq;
            rx_sens_20db <= nxt_eq;
            los_level <= nxt_eq ? rx_cfg1_ff[LOS_LVL_LSB +: 5] : 5'h00;
            slicer_threshold <= hw_mode ? SLICER_THRESHOLD_HW : rx_cfg2_ff[SLICER_THRESHOLD_LSB +: 2];
            rx_mode <= nxt_rx_mode;
            tx_mode <= nxt_tx_mode;
            cdr_bypass <= nxt_bypass;
        end
    end

    // Waveform store: 64 user samples plus the two preset tables, generated per entry.
    localparam int WAVE_DEPTH = WAVE_UI * WAVE_SAMPLES;
    logic [6:0] wave_ram [WAVE_DEPTH];
    logic [6:0] rom75 [WAVE_DEPTH];
    logic [6:0] rom120 [WAVE_DEPTH];
    genvar e;
    generate
        for (e = 0; e < WAVE_DEPTH; e++) begin : g_rom
            localparam logic [5:0] EA = 6'(e);
            localparam bit IN_UI1 = (EA[5:4] == 2'h0);
            localparam bit EDGE = IN_UI1 && (EA[3:0] == TPL_EDGE_IDX);
            localparam bit FLAT = IN_UI1 && (EA[3:0] >= TPL_FLAT_FIRST)
                                 && (EA[3:0] <= TPL_FLAT_LAST);
            assign rom75[e] = EDGE ? TPL75_EDGE : (FLAT ? TPL75_FLAT : 7'h00);
            assign rom120[e] = EDGE ? TPL120_EDGE : (FLAT ? TPL120_FLAT : 7'h00);
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (wave_wr_en) begin
            wave_ram[wave_wr_addr] <= wave_wr_data;
        end
    end

    logic [5:0] wave_idx;
    logic [6:0] nxt_sample;
    assign wave_idx = {wave_ui, wave_samp};
    assign nxt_sample = arb_wave ? wave_ram[wave_idx]
                      : (nxt_pulse_template_select == PULSE_75 ? rom75[wave_idx] : rom120[wave_idx]);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wave_sample_data <= 7'h00;
        end else begin
            wave_sample_data <= nxt_sample;
        end
    end

    // Recovery clock: a UI counter realigned at the start of each slicer mark follows jitter,
    // and freewheels at the nominal rate while no pulses arrive, holding phase.
    logic [1:0] slc_prev_ff;
    logic [6:0] ph_ff;
    logic [6:0] nxt_ph;
    logic mark_edge;
    assign mark_edge = (slc_q != 2'h0) & (slc_prev_ff == 2'h0);
    assign nxt_ph = mark_edge ? 7'h00 : ((ph_ff == UI_LAST) ? 7'h00 : ph_ff + 7'h01);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            slc_prev_ff <= 2'h0;
            ph_ff <= 7'h00;
            rec_clk <= 1'b0;
            rec_clk_tick <= 1'b0;
        end else begin
            slc_prev_ff <= slc_q;
            ph_ff <= nxt_ph;
            rec_clk <= (nxt_ph < UI_HALF);
            rec_clk_tick <= (nxt_ph == UI_HALF);
        end
    end

    // Receive pins: slicer straight through in bypass, recovered data otherwise.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_data_pos <= 1'b0;
            rx_data_neg <= 1'b0;
        end else if (nxt_bypass) begin
            rx_data_pos <= slc_q[1];
            rx_data_neg <= slc_q[0];
        end else begin
            rx_data_pos <= cdr_pos;
            rx_data_neg <= cdr_neg;
        end
    end

    // Read port: unmapped addresses return zero; status shows effective settings.
    logic [7:0] status_word;
    logic [7:0] rd_word;
    logic [5:0] ra;
    assign ra = addr_q;
    assign status_word = {3'h0, equalizer_enable, cdr_bypass, hw_mode, tx_powerdown, driver_hiz};
    assign rd_word = (ra == ADDR_TERM_CFG) ? term_cfg_ff :
                     (ra == ADDR_TX_CFG0) ? tx_cfg0_ff :
                     (ra == ADDR_TX_CFG1) ? tx_cfg1_ff :
                     (ra == ADDR_TX_CFG2) ? {2'h0, scale_ff} :
                     (ra == ADDR_RX_CFG0) ? rx_cfg0_ff :
                     (ra == ADDR_RX_CFG1) ? rx_cfg1_ff :
                     (ra == ADDR_RX_CFG2) ? rx_cfg2_ff :
                     (ra == ADDR_STATUS) ? status_word : 8'h00;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            data_out <= rd_word;
            data_oe <= cs_q & rd_q & ~wr_q;
        end
    end
endmodule

// [efe_pkg.sv]
// Constants for one channel of the E1 line front-end control block.
// Assumes the parallel host port and all strap pins come from outside the sys_clk domain.
// Function
// - 75 ohm preset template contents
// - 120 ohm preset template contents
// - Scale field defaults 100001, 3 percent steps
// - Transmit termination select and pulse setting
// - Receive termination select
// - Driver high impedance by pin or bit
// - Driver high impedance on clock loss, reset
// - Transmit power-down bit floats driver
// - Hardware pattern pins 11 power down transmit
// - Hardware termination pin and pulse pins
// - Monitor gain field 0/22/26/32 dB
// - Hardware monitor pin gives 0 or 26 dB
// - Equalizer enable bit, deep loss-of-signal levels
// - Hardware mode: equalizer off, sensitivity -10 dB
// - Slicer threshold 40/50/60/70 percent
// - Recovery bypass only dual rail, slicer direct
// - Recovered clock tracks jitter, holds phase
// - Receive decoder select, hardware mode pins
// - Waveform store 4 UI by 16 samples
// - Preset templates ignore amplitude scaling
package efe_pkg;
    localparam logic [5:0] ADDR_TERM_CFG = 6'h02;
    localparam logic [5:0] ADDR_TX_CFG0 = 6'h04;
    localparam logic [5:0] ADDR_TX_CFG1 = 6'h05;
    localparam logic [5:0] ADDR_TX_CFG2 = 6'h06;
    localparam logic [5:0] ADDR_RX_CFG0 = 6'h09;
    localparam logic [5:0] ADDR_RX_CFG1 = 6'h0a;
    localparam logic [5:0] ADDR_RX_CFG2 = 6'h0b;
    localparam logic [5:0] ADDR_STATUS = 6'h3e;
    localparam logic [7:0] RST_TERM_CFG = 8'h00;
    localparam logic [7:0] RST_TX_CFG0 = 8'h00;
    localparam logic [7:0] RST_TX_CFG1 = 8'h00;
    localparam logic [5:0] RST_AMP_SCALE = 6'h21;
    localparam logic [7:0] RST_RX_CFG0 = 8'h00;
    localparam logic [7:0] RST_RX_CFG1 = 8'h00;
    localparam logic [7:0] RST_RX_CFG2 = 8'h00;
    localparam int TX_TERM_LSB = 0;
    localparam int RX_TERM_LSB = 3;
    localparam int TX_OFF_BIT = 4;
    localparam int TX_MODE_LSB = 0;
    localparam int DRV_HIZ_BIT = 5;
    localparam int PULSE_LSB = 0;
    localparam int RX_MODE_LSB = 0;
    localparam int RX_OFF_BIT = 4;
    localparam int EQ_EN_BIT = 6;
    localparam int LOS_LVL_LSB = 0;
    localparam int MON_GAIN_LSB = 0;
    localparam int SLICER_THRESHOLD_LSB = 2;
    localparam logic [3:0] PULSE_75 = 4'h0;
    localparam logic [3:0] PULSE_120 = 4'h1;
    localparam logic [1:0] PULSE_ARB_TOP = 2'h3;
    localparam logic [1:0] GAIN_0DB = 2'h0;
    localparam logic [1:0] GAIN_26DB = 2'h2;
    localparam logic [1:0] SLICER_THRESHOLD_HW = 2'h1;
    localparam logic [1:0] CTRL_MODE_HW = 2'h0;
    localparam logic [1:0] PAT_TX_OFF = 2'h3;
    localparam logic [1:0] RX_MODE_BYPASS = 2'h3;
    localparam logic [6:0] TPL75_EDGE = 7'h0c;
    localparam logic [6:0] TPL75_FLAT = 7'h30;
    localparam logic [6:0] TPL120_EDGE = 7'h0f;
    localparam logic [6:0] TPL120_FLAT = 7'h3c;
    localparam logic [3:0] TPL_EDGE_IDX = 4'h3;
    localparam logic [3:0] TPL_FLAT_FIRST = 4'h4;
    localparam logic [3:0] TPL_FLAT_LAST = 4'hb;
    localparam int WAVE_UI = 4;
    localparam int WAVE_SAMPLES = 16;
    localparam int SYS_CLK_KHZ = 125000;
    localparam int LINE_RATE_KHZ = 2048;
    localparam int UI_CYCLES = SYS_CLK_KHZ / LINE_RATE_KHZ;
    localparam logic [6:0] UI_LAST = 7'(UI_CYCLES - 1);
    localparam logic [6:0] UI_HALF = 7'(UI_CYCLES / 2);
endpackage

// [efe_sync.sv]
// Three-stage pin synchroniser with a glitch filter on the last two stages.
// Assumes the inputs are levels from outside the sys_clk domain.
`timescale 1ns/1ps
module efe_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // A bit only moves once stages two and three agree, so one-cycle glitches die.
            assign nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q_ff[i];
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_ff <= INIT;
            s2_ff <= INIT;
            s3_ff <= INIT;
            q_ff <= INIT;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;
endmodule

// [efe_ctrl_assertions.sv]
// Checker for efe_ctrl: pins and decoded outputs tied together over time.
// Assumes it is bound into every efe_ctrl instance and sees only its ports.
`timescale 1ns/1ps
module efe_ctrl_checker (
    input logic sys_clk,
    input logic rst,
    input logic [1:0] ctrl_mode_pins,
    input logic [1:0] pattern_select_pins,
    input logic monitor_gain_pin,
    input logic mclk_lost,
    input logic tclk_lost,
    input logic remote_loopback,
    input logic pattern_on_mclk,
    input logic soft_reset,
    input logic [1:0] wave_ui,
    input logic [3:0] wave_samp,
    input logic [3:0] pulse_template_select,
    input logic [5:0] amplitude_scale,
    input logic [6:0] wave_sample_data,
    input logic tx_powerdown,
    input logic driver_hiz,
    input logic [1:0] monitor_gain,
    input logic equalizer_enable,
    input logic rx_sens_20db
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Pins pass a filter, so strap checks wait eight settled cycles first.
    wire logic hw = ctrl_mode_pins == 2'h0;
    wire logic [5:0] idx = {wave_ui, wave_samp};
    property p_hiz_loss;
        mclk_lost || soft_reset || (tclk_lost && !remote_loopback && !pattern_on_mclk)
            |-> ##[1:2] driver_hiz;
    endproperty
    a_hiz_loss: assert property (p_hiz_loss) else $error("driver not floated");
    property p_hiz_pd;
        tx_powerdown [*2] |-> driver_hiz;
    endproperty
    a_hiz_pd: assert property (p_hiz_pd) else $error("powered down driver");
    property p_hw_pd;
        (hw && pattern_select_pins == 2'h3) [*8] |-> tx_powerdown;
    endproperty
    a_hw_pd: assert property (p_hw_pd) else $error("pattern pins ignored");
    property p_hw_mon;
        (hw && $stable(monitor_gain_pin)) [*8] |-> monitor_gain == (monitor_gain_pin ? 2'h2 : 2'h0);
    endproperty
    a_hw_mon: assert property (p_hw_mon) else $error("monitor pin gain");
    property p_hw_eq;
        hw [*8] |-> !equalizer_enable && !rx_sens_20db;
    endproperty
    a_hw_eq: assert property (p_hw_eq) else $error("equalizer on in pin mode");
    property p_preset_scale;
        pulse_template_select[3:2] != 2'h3 && $stable(pulse_template_select)
            |-> amplitude_scale == 6'h21;
    endproperty
    a_preset_scale: assert property (p_preset_scale) else $error("preset scaled");
    property p_rom75;
        pulse_template_select == 4'h0 && idx == 6'h03 |=> wave_sample_data == 7'h0c;
    endproperty
    a_rom75: assert property (p_rom75) else $error("75 ohm edge sample");
    property p_rom120;
        pulse_template_select == 4'h1 && idx inside {[6'h04:6'h0b]} |=> wave_sample_data == 7'h3c;
    endproperty
    a_rom120: assert property (p_rom120) else $error("120 ohm flat sample");
endmodule

bind efe_ctrl efe_ctrl_checker efe_ctrl_checker_inst (.*);

// [efe_line_model.sv]
// Behavioural line receiver feeding the slicer outputs of the control block.
// Assumes sys_clk is the block clock; a mark lasts half a unit interval.
`timescale 1ns/1ps
module efe_line_model (
    input wire logic sys_clk,
    input wire logic [1:0] line_mode,
    output logic slicer_pos,
    output logic slicer_neg
);
    import efe_pkg::*;
    int ph = 0;
    logic pol = 1'b0;
    // Mode 0 is a quiet line, 1 alternating marks each interval, 2 a held mark.
    always @(posedge sys_clk) begin
        ph <= (ph == UI_CYCLES - 1) ? 0 : ph + 1;
        if (ph == UI_CYCLES - 1) pol <= !pol;
    end
    assign slicer_pos = line_mode == 2'h2 || (line_mode == 2'h1 && !pol && ph < UI_CYCLES / 2);
    assign slicer_neg = line_mode == 2'h1 && pol && ph < UI_CYCLES / 2;
endmodule

// [efe_ctrl_bench.sv]
// Self-checking bench for efe_ctrl with the line model beside it.
// Assumes the package, the model and the bound checker compile first.
`timescale 1ns/1ps
module efe_ctrl_bench;
    import efe_pkg::*;
    logic sys_clk, rst, cs_n, rd_n, wr_n, driver_hiz_pin, term_mode_pin, monitor_gain_pin;
    logic mclk_lost, tclk_lost, remote_loopback, pattern_on_mclk, soft_reset, wave_wr_en;
    logic cdr_pos, cdr_neg;
    logic [1:0] ctrl_mode_pins, pattern_select_pins, pulse_select_pins, path_mode_pins;
    logic [1:0] wave_ui, line_mode;
    logic [3:0] wave_samp;
    logic [5:0] addr, wave_wr_addr;
    logic [6:0] wave_wr_data;
    logic [7:0] data_in;
    wire logic slicer_pos, slicer_neg, data_oe, tx_term_internal, tx_term_120, rx_term_internal;
    wire logic rx_term_120, tx_powerdown, driver_hiz, equalizer_enable, rx_sens_20db;
    wire logic cdr_bypass, rx_data_pos, rec_clk_tick, rx_powerdown;
    wire logic [1:0] monitor_gain, slicer_threshold, rx_mode, tx_mode;
    wire logic [3:0] pulse_template_select;
    wire logic [4:0] los_level;
    wire logic [5:0] amplitude_scale;
    wire logic [6:0] wave_sample_data;
    wire logic [7:0] data_out;
    wire logic [3:0] terms = {tx_term_internal, tx_term_120, rx_term_internal, rx_term_120};
    int errors = 0;
    int check_count = 0;
    efe_ctrl efe_ctrl_inst (.*, .rx_data_neg(), .rec_clk());
    efe_line_model efe_line_model_inst (.*);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task w(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Strobes and gaps outlast the pin filters so no access is swallowed.
    task wr(input logic [5:0] a, input logic [7:0] d);
        addr = a;
        data_in = d;
        {cs_n, wr_n} = 2'h0;
        w(8);
        {cs_n, wr_n} = 2'h3;
        w(14);
    endtask
    task rd(input logic [5:0] a, input logic [7:0] e);
        addr = a;
        {cs_n, rd_n} = 2'h0;
        w(8);
        chk(data_out, e);
        chk(8'(data_oe), 8'h01);
        {cs_n, rd_n} = 2'h3;
        w(10);
    endtask
    function logic [6:0] rom(input logic hi, input int i);
        if (i == 3) return hi ? 7'h0f : 7'h0c;
        if (i >= 4 && i <= 11) return hi ? 7'h3c : 7'h30;
        return 7'h00;
    endfunction
    task t_term;
        logic [1:0] e;
        for (int i = 0; i < 3; i++) begin
            e = (i == 2) ? 2'h0 : {1'b1, i[0]};
            wr(ADDR_TERM_CFG, (i == 2) ? 8'h24 : 8'(i * 9));
            chk(8'(terms), {4'h0, e, e});
        end
        $display("test term done");
    endtask
    task t_wave;
        wr(ADDR_TX_CFG1, 8'h00);
        wr(ADDR_TX_CFG2, 8'h22);
        chk(8'(amplitude_scale), 8'h21);
        rd(ADDR_TX_CFG2, 8'h22);
        wr(ADDR_TX_CFG1, 8'h0c);
        chk(8'(amplitude_scale), 8'h22);
        wave_wr_addr = 6'h3f;
        wave_wr_data = 7'h7f;
        wave_wr_en = 1'b1;
        w(1);
        wave_wr_en = 1'b0;
        {wave_ui, wave_samp} = 6'h3f;
        w(2);
        chk(8'(wave_sample_data), 8'h7f);
        for (int p = 0; p < 2; p++) begin
            wr(ADDR_TX_CFG1, 8'(p));
            for (int i = 0; i < 64; i++) begin
                {wave_ui, wave_samp} = 6'(i);
                w(2);
                chk(8'(wave_sample_data), 8'(rom(p == 1, i)));
            end
        end
        $display("test wave done");
    endtask
    task hz(input logic e);
        w(12);
        chk(8'(driver_hiz), 8'(e));
    endtask
    task t_hiz;
        hz(1'b0);
        driver_hiz_pin = 1'b1;
        hz(1'b1);
        driver_hiz_pin = 1'b0;
        wr(ADDR_TX_CFG1, 8'h20);
        hz(1'b1);
        wr(ADDR_TX_CFG1, 8'h00);
        wr(ADDR_TX_CFG0, 8'h10);
        chk(8'(tx_powerdown), 8'h01);
        hz(1'b1);
        wr(ADDR_TX_CFG0, 8'h00);
        mclk_lost = 1'b1;
        hz(1'b1);
        mclk_lost = 1'b0;
        tclk_lost = 1'b1;
        hz(1'b1);
        remote_loopback = 1'b1;
        hz(1'b0);
        {remote_loopback, pattern_on_mclk} = 2'h1;
        hz(1'b0);
        {tclk_lost, pattern_on_mclk, soft_reset} = 3'h1;
        hz(1'b1);
        soft_reset = 1'b0;
        hz(1'b0);
        $display("test hiz done");
    endtask
    task t_rx;
        wr(ADDR_RX_CFG1, 8'h5f);
        chk({equalizer_enable, rx_sens_20db, 1'b0, los_level}, 8'hdf);
        wr(ADDR_RX_CFG1, 8'h1f);
        chk({equalizer_enable, rx_sens_20db, 1'b0, los_level}, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_RX_CFG2, 8'(k * 5));
            chk({4'h0, monitor_gain, slicer_threshold}, 8'(k * 5));
            wr(ADDR_RX_CFG0, 8'(k * 17));
            chk({4'h0, rx_powerdown, cdr_bypass, rx_mode}, 8'({k[0], k == 3, k[1:0]}));
        end
        line_mode = 2'h2;
        w(12);
        chk(8'(rx_data_pos), 8'h01);
        line_mode = 2'h0;
        w(12);
        chk(8'(rx_data_pos), 8'h00);
        wr(ADDR_RX_CFG0, 8'h02);
        cdr_pos = 1'b1;
        w(3);
        chk(8'(rx_data_pos), 8'h01);
        cdr_pos = 1'b0;
        $display("test rx done");
    endtask
    task t_clk;
        int n;
        line_mode = 2'h1;
        w(400);
        line_mode = 2'h0;
        n = 0;
        while (rec_clk_tick !== 1'b1) begin
            w(1);
            n++;
            if (n > 70) begin
                errors++;
                summarize();
            end
        end
        n = 0;
        repeat (UI_CYCLES * 3) begin
            w(1);
            n += int'(rec_clk_tick === 1'b1);
        end
        chk(8'(n), 8'h03);
        $display("test clock done");
    endtask
    task t_hw;
        wr(ADDR_RX_CFG1, 8'h40);
        wr(ADDR_TX_CFG1, 8'h20);
        ctrl_mode_pins = 2'h0;
        {pattern_select_pins, pulse_select_pins, path_mode_pins} = 6'h36;
        monitor_gain_pin = 1'b1;
        w(12);
        chk({equalizer_enable, rx_sens_20db, tx_powerdown, driver_hiz}, 8'h03);
        chk({monitor_gain, tx_mode, rx_mode}, 8'h2a);
        chk({pulse_template_select, terms}, 8'h1f);
        rd(ADDR_STATUS, 8'h07);
        {pattern_select_pins, pulse_select_pins, monitor_gain_pin} = 5'h0;
        w(12);
        chk({pulse_template_select, terms}, 8'h0a);
        chk({monitor_gain, driver_hiz}, 8'h00);
        term_mode_pin = 1'b1;
        w(12);
        chk({pulse_template_select, terms[3], terms[1]}, 8'h04);
        $display("test pins done");
    endtask
    initial begin
        {rst, cs_n, rd_n, wr_n, ctrl_mode_pins} = 6'h3f;
        {driver_hiz_pin, term_mode_pin, monitor_gain_pin, mclk_lost, tclk_lost} = 5'h0;
        {remote_loopback, pattern_on_mclk, soft_reset, wave_wr_en, cdr_pos, cdr_neg} = 6'h0;
        {pattern_select_pins, pulse_select_pins, path_mode_pins, wave_ui, line_mode} = 10'h0;
        {wave_samp, addr, wave_wr_addr, wave_wr_data, data_in} = 31'h0;
        w(3);
        chk(8'(driver_hiz), 8'h01);
        w(1);
        rst = 1'b0;
        w(12);
        rd(ADDR_TERM_CFG, 8'h00);
        rd(ADDR_TX_CFG2, 8'h21);
        rd(6'h3d, 8'h00);
        t_term();
        t_wave();
        t_hiz();
        t_rx();
        t_clk();
        t_hw();
        summarize();
    end
endmodule
